/* File: dv/ccp_far_side_model.sv */
// Purpose: Far side: switch driver loads and capture input source
// Assumes: Pins A..F at bits 0..5, one clock
// Notes: Nets have no pull, so a released pin shows the inverse of its last level
`timescale 1ns/1ps
module ccp_far_side_model (
    input wire logic i_clock,
    input wire logic [5:0] i_pin_out,
    input wire logic [5:0] i_pin_oe,
    input wire logic i_edge_req,
    output logic o_capture_pin,
    output logic [5:0] o_pin_level
);
    logic [5:0] last_q = 6'h00;
    initial o_capture_pin = 1'b0;
    always_comb o_pin_level = (i_pin_out & i_pin_oe) | (~last_q & ~i_pin_oe);
    always @(posedge i_clock) begin
        last_q <= o_pin_level;
        // Each request is one edge of the capture source
        if (i_edge_req) begin
            o_capture_pin <= ~o_capture_pin;
        end
    end
endmodule

/* File: dv/ccp_output_shaping_status_bench.sv */
// Purpose: Self-checking bench for the output-shaping and status block
// Assumes: Tick every cycle while enabled, so counts are in clock cycles
// Notes: Settled outputs are sampled 1 ns after the edge
`timescale 1ns/1ps
module ccp_output_shaping_status_bench;
    localparam logic [11:0] DT = ccp_shape_pkg::OFF_DEAD_TIME;
    localparam logic [11:0] OM = ccp_shape_pkg::OFF_OUT_MODE;
    localparam logic [11:0] ST = ccp_shape_pkg::OFF_STATUS;
    localparam logic [11:0] CT = ccp_shape_pkg::OFF_CONTROL;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [11:0] i_addr = 12'h000;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0, i_rd = 1'b0, tick = 1'b0, pwm = 1'b0, sd = 1'b0, fne = 1'b0, gate = 1'b0;
    logic [5:0] pv = 6'h00;
    logic [15:0] o_rdata;
    logic [5:0] o_pin_out, o_pin_oe, lvl;
    logic o_capture_event, o_one_shot_active, cap_pin;
    logic [31:0] seed = 32'hd9f0_89f3;
    int n_mismatch = 0, compares = 0, ncap = 0, cyc_n = 0, n, c0;
    logic [15:0] r, eo, ee;
    int dts[$] = '{0, 1, 5, 63};

    always #2.5 i_clock = ~i_clock;

    ccp_output_shaping_status i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(1'b1),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_tb_tick(tick), .i_period_start(pv[4]), .i_pwm(pwm), .i_one_shot(pv[2]),
        .i_ext_trigger(pv[3]), .i_shutdown(sd), .i_compare_event(pv[0]),
        .i_fifo_overflow(pv[1]), .i_fifo_not_empty(fne), .i_capture_input_pin(cap_pin),
        .i_gate_source(gate), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_capture_event(o_capture_event), .o_one_shot_active(o_one_shot_active));

    ccp_far_side_model i_far (.i_clock(i_clock), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
        .i_edge_req(pv[5]), .o_capture_pin(cap_pin), .o_pin_level(lvl));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic end_sim();
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge i_clock);
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata & m, e);
    endtask

    task automatic pls(input int i);
        @(posedge i_clock);
        pv <= 6'h01 << i;
        @(posedge i_clock);
        pv <= 6'h00;
    endtask

    // Count settled cycles where a condition on the outputs holds
    task automatic cnt(input int w, input bit os, output int k);
        k = 0;
        repeat (w) begin
            #1;
            if (os ? (o_one_shot_active === 1'b1) : (o_pin_out[1:0] === 2'b00)) k++;
            @(posedge i_clock);
        end
    endtask

    always @(posedge i_clock) begin
        cyc_n++;
        if (o_capture_event === 1'b1) ncap++;
        if (cyc_n == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        cyc(5);
        i_rst <= 1'b0;
        tick <= 1'b1;
        rchk(ST, 16'h04E0, 16'h0080);
        rchk(12'h2A0, 16'hFFFF, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            r = seed[15:0];
            wr(DT, r);
            rchk(DT, 16'h003F, r & 16'h003F);
        end
        foreach (dts[i]) begin
            wr(OM, {5'h00, ccp_shape_pkg::OUTM_HALF_BRIDGE, 8'h00});
            wr(DT, 16'(dts[i]));
            pwm <= 1'b1;
            cnt(120, 1'b0, n);
            chk(16'(n), 16'(dts[i]));
            pwm <= 1'b0;
            cnt(120, 1'b0, n);
            chk(16'(n), 16'(dts[i]));
        end
        for (int m = 0; m < 7; m++) begin
            if (m == 3) continue;
            wr(OM, 16'(m) << 8);
            rchk(OM, 16'hF73F, 16'(m) << 8);
        end
        for (int k = 0; k < 8; k++) begin
            wr(OM, 16'(k) << 12);
            pls(2);
            cnt(40, 1'b1, n);
            chk(16'(n), 16'(k + 1));
        end
        wr(CT, 16'h0001);
        wr(OM, 16'h8200);
        wr(ST, 16'h0020);
        rchk(ST, 16'h04E0, 16'h0000);
        cyc(4);
        #1;
        chk({10'h000, o_pin_oe}, 16'h0000);
        wr(ST, 16'h0040);
        rchk(ST, 16'h04E0, 16'h0080);
        wr(ST, 16'h0020);
        pls(3);
        rchk(ST, 16'h0080, 16'h0080);
        wr(CT, 16'h0000);
        wr(ST, 16'h0000);
        pls(0);
        pls(1);
        fne <= 1'b1;
        cyc(2);
        rchk(ST, 16'h000B, 16'h000B);
        rchk(ST, 16'h000B, 16'h000B);
        wr(ST, 16'h0000);
        fne <= 1'b0;
        cyc(2);
        rchk(ST, 16'h000B, 16'h0000);
        for (int g = 1; g >= 0; g--) begin
            gate <= g[0];
            cyc(8);
            c0 = ncap;
            repeat (4) begin
                pls(5);
                cyc(8);
            end
            chk(16'(ncap - c0), g ? 16'h0004 : 16'h0000);
            rchk(ST, 16'h0004, g ? 16'h0000 : 16'h0004);
        end
        wr(CT, 16'h0008);
        gate <= 1'b1;
        cyc(8);
        wr(ST, 16'h0400);
        rchk(ST, 16'h0404, 16'h0000);
        gate <= 1'b0;
        cyc(8);
        rchk(ST, 16'h0004, 16'h0004);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            r = seed[15:0] & 16'h003F;
            wr(OM, r);
            wr(CT, 16'h0002);
            sd <= 1'b1;
            cyc(8);
            #1;
            eo = {10'h000, {3{r[1], r[3]}}};
            ee = {10'h000, {3{r[0] ^ r[4], r[2] ^ r[5]}}} & eo;
            chk({10'h000, o_pin_oe}, eo);
            chk({10'h000, o_pin_out & o_pin_oe}, ee);
            chk({10'h000, lvl & o_pin_oe}, ee);
            chk({10'h000, lvl & o_pin_oe}, ee);
            rchk(ST, 16'h0010, 16'h0010);
            sd <= 1'b0;
            cyc(6);
            pls(4);
            cyc(4);
            rchk(ST, 16'h0010, 16'h0000);
        end
        end_sim();
    end
endmodule

/* File: rtl/ccp_output_shaping_status.sv */
// Purpose: Dead time, one-shot extension, output modes, polarity, shutdown, status
// Assumes: Time base, FIFO and compare logic supply one-cycle event pulses
// Notes: Pins are six outputs with enables; undriven means enable low
`timescale 1ns/1ps
module ccp_output_shaping_status #(
    parameter int DT_WIDTH = ccp_shape_pkg::DT_W
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic [11:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic i_tb_tick,
    input wire logic i_period_start,
    input wire logic i_pwm,
    input wire logic i_one_shot,
    input wire logic i_ext_trigger,
    input wire logic i_shutdown,
    input wire logic i_compare_event,
    input wire logic i_fifo_overflow,
    input wire logic i_fifo_not_empty,
    input wire logic i_capture_input_pin,
    input wire logic i_gate_source,
    output logic [5:0] o_pin_out,
    output logic [5:0] o_pin_oe,
    output logic o_capture_event,
    output logic o_one_shot_active
);
    typedef struct packed {
        logic [DT_WIDTH-1:0] dt;
        logic hold;
        logic [2:0] oscnt;
        logic [2:0] outm;
        logic pol1;
        logic pol2;
        logic [1:0] pss1;
        logic [1:0] pss2;
        logic trig_en;
        logic restart_en;
        logic [1:0] gsm;
        logic trig;
        logic asd;
        logic sce;
        logic cap_dis;
        logic ovf;
        logic gate_armed;
        logic pwm_prev;
        logic [DT_WIDTH-1:0] dt_cnt;
        logic hi_en;
        logic lo_en;
        logic [2:0] os_cnt;
        logic os_act;
        logic dir_tog;
        logic [2:0] scan_idx;
        logic [1:0] cap_sync;
        logic cap_prev;
        logic [1:0] gate_sync;
        logic gate_prev;
        logic [1:0] sd_sync;
        logic [5:0] pin;
        logic [5:0] oe;
        logic cap_evt;
        logic [15:0] rdata;
    } state_t;

    state_t q, d;

    // Polarity group: even pins are A, C, E
    function automatic logic pin_pol(input int idx, input logic p1, input logic p2);
        return (idx % 2 == 0) ? p1 : p2;
    endfunction

    logic [5:0] act_level;
    logic [5:0] enable_mask;
    logic cap_edge;
    logic gate_rise;
    logic gate_fall;
    logic sd_now;

    always_comb begin
        d = q;
        cap_edge = q.cap_sync[1] ^ q.cap_prev;
        gate_rise = q.gate_sync[1] & ~q.gate_prev;
        gate_fall = ~q.gate_sync[1] & q.gate_prev;
        sd_now = q.sd_sync[1];
        act_level = 6'h00;
        enable_mask = 6'h3F;
        d.cap_sync = {q.cap_sync[0], i_capture_input_pin};
        d.cap_prev = q.cap_sync[1];
        d.gate_sync = {q.gate_sync[0], i_gate_source};
        d.gate_prev = q.gate_sync[1];
        d.sd_sync = {q.sd_sync[0], i_shutdown};
        d.pwm_prev = i_pwm;
        d.rdata = 16'h0000;

        if (i_rd) begin
            case (i_addr)
                ccp_shape_pkg::OFF_DEAD_TIME: d.rdata = 16'(q.dt);
                ccp_shape_pkg::OFF_OUT_MODE: d.rdata = {q.hold, q.oscnt, 1'b0, q.outm,
                    2'b00, q.pol1, q.pol2, q.pss1, q.pss2};
                ccp_shape_pkg::OFF_STATUS: d.rdata = {8'h00, q.trig, 2'b00,
                    q.asd, q.sce, q.cap_dis, q.ovf, i_fifo_not_empty};
                ccp_shape_pkg::OFF_CONTROL: d.rdata = {12'h000, q.gsm, q.restart_en, q.trig_en};
                default: d.rdata = 16'h0000;
            endcase
        end

        // Hardware sets after software clears, so a coincident event wins
        if (i_wr) begin
            case (i_addr)
                ccp_shape_pkg::OFF_DEAD_TIME: d.dt = i_wdata[DT_WIDTH-1:0];
                ccp_shape_pkg::OFF_OUT_MODE: begin
                    d.hold = i_wdata[ccp_shape_pkg::B_HOLD_TRIG];
                    d.oscnt = i_wdata[ccp_shape_pkg::B_OSCNT_LO +: 3];
                    d.outm = i_wdata[ccp_shape_pkg::B_OUTM_LO +: 3];
                    d.pol1 = i_wdata[ccp_shape_pkg::B_POL_ONE];
                    d.pol2 = i_wdata[ccp_shape_pkg::B_POL_TWO];
                    d.pss1 = i_wdata[ccp_shape_pkg::B_PSS_ONE_LO +: 2];
                    d.pss2 = i_wdata[ccp_shape_pkg::B_PSS_TWO_LO +: 2];
                end
                ccp_shape_pkg::OFF_STATUS: begin
                    if (i_wdata[ccp_shape_pkg::B_GATE_ARM] &&
                        (q.gsm == ccp_shape_pkg::GSM_RISE || q.gsm == ccp_shape_pkg::GSM_FALL))
                        d.gate_armed = 1'b1;
                    if (q.trig_en && i_wdata[ccp_shape_pkg::B_TRIG_SET])
                        d.trig = 1'b1;
                    if (q.trig_en && i_wdata[ccp_shape_pkg::B_TRIG_CLR])
                        d.trig = 1'b0;
                    if (!i_wdata[ccp_shape_pkg::B_ASD])
                        d.asd = 1'b0;
                    if (!i_wdata[ccp_shape_pkg::B_SCE])
                        d.sce = 1'b0;
                    if (!i_wdata[ccp_shape_pkg::B_CAP_DIS])
                        d.cap_dis = 1'b0;
                    if (!i_wdata[ccp_shape_pkg::B_OVF])
                        d.ovf = 1'b0;
                end
                ccp_shape_pkg::OFF_CONTROL: begin
                    d.trig_en = i_wdata[ccp_shape_pkg::B_TRIG_EN];
                    d.restart_en = i_wdata[ccp_shape_pkg::B_RESTART_EN];
                    d.gsm = i_wdata[ccp_shape_pkg::B_GSM_LO +: 2];
                end
                default: ;
            endcase
        end

        // Trigger mode off means the timer free-runs
        if (!d.trig_en)
            d.trig = 1'b1;
        else if (i_ext_trigger)
            d.trig = 1'b1;

        if (sd_now)
            d.asd = 1'b1;
        else if (q.restart_en && q.asd && i_period_start)
            d.asd = 1'b0;
        if (i_compare_event)
            d.sce = 1'b1;
        if (i_fifo_overflow)
            d.ovf = 1'b1;

        // Capture gating
        case (q.gsm)
            ccp_shape_pkg::GSM_LEVEL: d.cap_dis = ~q.gate_sync[1];
            ccp_shape_pkg::GSM_RISE:
                if (q.gate_armed && gate_rise) begin
                    d.cap_dis = 1'b0;
                    d.gate_armed = 1'b0;
                end
            ccp_shape_pkg::GSM_FALL:
                if (q.gate_armed && gate_fall) begin
                    d.cap_dis = 1'b1;
                    d.gate_armed = 1'b0;
                end
            default: ;
        endcase
        d.cap_evt = cap_edge & ~q.cap_dis;

        // One-shot extension counted in time base ticks
        if (i_one_shot) begin
            d.os_act = 1'b1;
            d.os_cnt = q.oscnt;
        end else if (q.os_act && i_tb_tick) begin
            if (q.os_cnt == 3'h0)
                d.os_act = 1'b0;
            else
                d.os_cnt = q.os_cnt - 3'h1;
        end

        // Dead time: each pwm edge with nonzero dead time blanks both outputs, then the new side turns on
        if (i_pwm != q.pwm_prev) begin
            // Edge cycle is the first blank period, so load one less
            d.dt_cnt = (q.dt == '0) ? q.dt : q.dt - DT_WIDTH'(1);
            d.hi_en = (q.dt == '0) ? i_pwm : 1'b0;
            d.lo_en = (q.dt == '0) ? ~i_pwm : 1'b0;
        end else if (q.dt_cnt != '0) begin
            if (i_tb_tick)
                d.dt_cnt = q.dt_cnt - 1'b1;
        end else begin
            d.hi_en = i_pwm;
            d.lo_en = ~i_pwm;
        end
        if (i_period_start) begin
            d.dir_tog = ~q.dir_tog;
            d.scan_idx = (q.scan_idx == 3'h5) ? 3'h0 : q.scan_idx + 3'h1;
        end

        case (q.outm)
            ccp_shape_pkg::OUTM_SINGLE: act_level = {6{q.hi_en}};
            ccp_shape_pkg::OUTM_PUSH_PULL: act_level = q.dir_tog ? {3{1'b0, q.hi_en}}
                : {3{q.hi_en, 1'b0}};
            ccp_shape_pkg::OUTM_HALF_BRIDGE: act_level = {3{q.lo_en, q.hi_en}};
            ccp_shape_pkg::OUTM_BDC_REV: act_level = {4'h0, q.hi_en, 1'b1};
            ccp_shape_pkg::OUTM_BDC_FWD: act_level = {q.hi_en, 4'h0, 1'b1};
            ccp_shape_pkg::OUTM_SCAN: act_level = 6'(q.hi_en) << q.scan_idx;
            default: act_level = 6'h00;
        endcase
        if (q.outm == ccp_shape_pkg::OUTM_BDC_REV || q.outm == ccp_shape_pkg::OUTM_BDC_FWD)
            enable_mask = (q.outm == ccp_shape_pkg::OUTM_BDC_REV) ? 6'h03 : 6'h21;

        for (int i = 0; i < 6; i++) begin
            logic [1:0] pss;
            logic pol;
            pss = (i % 2 == 0) ? q.pss1 : q.pss2;
            pol = pin_pol(i, q.pol1, q.pol2);
            if (q.asd) begin
                d.pin[i] = pss[0] ^ pol;
                d.oe[i] = pss[1];
            end else begin
                d.pin[i] = act_level[i] ^ pol;
                d.oe[i] = enable_mask[i] & ~(q.hold & q.trig_en & ~q.trig);
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            q <= '0;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    assign o_rdata = q.rdata;
    assign o_pin_out = q.pin;
    assign o_pin_oe = q.oe;
    assign o_capture_event = q.cap_evt;
    assign o_one_shot_active = q.os_act;

    a_sce_sticky: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_compare_event) |=> q.sce)
        else $error("compare event flag not set");
    a_ovf_sticky: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_fifo_overflow) |=> q.ovf)
        else $error("overflow flag not set");
    a_hold_oe: assert property (@(posedge i_clock) disable iff (i_rst)
        (q.hold && q.trig_en && !q.trig && !q.asd && i_clk_en) |=> (o_pin_oe == 6'h00))
        else $error("pins driven before trigger");
    a_cap_block: assert property (@(posedge i_clock) disable iff (i_rst)
        (q.cap_dis && i_clk_en) |=> !o_capture_event)
        else $error("capture while disabled");
    a_shutdown_set: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && q.sd_sync[1]) |=> q.asd)
        else $error("shutdown status not set");
    a_shutdown_tri: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && q.asd && !q.pss1[1]) |=> (o_pin_oe[0] == 1'b0))
        else $error("group one pin driven in tristate shutdown");
    a_trig_set: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_wr && i_addr == ccp_shape_pkg::OFF_STATUS && q.trig_en
        && i_wdata[6] && !i_wdata[5]) |=> q.trig)
        else $error("trigger set ignored");
    a_dead_gap: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_pwm != q.pwm_prev && q.dt != '0) |=> (!q.hi_en && !q.lo_en))
        else $error("no dead time after edge");
    a_one_shot: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_clk_en && i_one_shot) |=> o_one_shot_active)
        else $error("one-shot not started");
endmodule

/* File: rtl/ccp_shape_pkg.sv */
// Purpose: Constants for the capture/compare output-shaping and status block
// Assumes: Register bus with 16-bit data, addresses are byte offsets
// Notes: Bit positions follow the register layout of the unit
package ccp_shape_pkg;
    localparam logic [11:0] OFF_DEAD_TIME = 12'h0298;
    localparam logic [11:0] OFF_OUT_MODE = 12'h029A;
    localparam logic [11:0] OFF_STATUS = 12'h029C;
    localparam logic [11:0] OFF_CONTROL = 12'h029E;
    localparam int DT_W = 6;
    localparam int B_HOLD_TRIG = 15;
    localparam int B_OSCNT_LO = 12;
    localparam int B_OUTM_LO = 8;
    localparam int B_POL_ONE = 5;
    localparam int B_POL_TWO = 4;
    localparam int B_PSS_ONE_LO = 2;
    localparam int B_PSS_TWO_LO = 0;
    localparam int B_GATE_ARM = 10;
    localparam int B_TRIG_STAT = 7;
    localparam int B_TRIG_SET = 6;
    localparam int B_TRIG_CLR = 5;
    localparam int B_ASD = 4;
    localparam int B_SCE = 3;
    localparam int B_CAP_DIS = 2;
    localparam int B_OVF = 1;
    localparam int B_BNE = 0;
    // Own control register: trigger enable, restart enable, gating mode
    localparam int B_TRIG_EN = 0;
    localparam int B_RESTART_EN = 1;
    localparam int B_GSM_LO = 2;
    localparam logic [1:0] PSS_ACTIVE = 2'h3;
    localparam logic [1:0] PSS_INACTIVE = 2'h2;
    localparam logic [1:0] GSM_LEVEL = 2'h0;
    localparam logic [1:0] GSM_RISE = 2'h1;
    localparam logic [1:0] GSM_FALL = 2'h2;
    localparam logic [2:0] OUTM_SINGLE = 3'h0;
    localparam logic [2:0] OUTM_PUSH_PULL = 3'h1;
    localparam logic [2:0] OUTM_HALF_BRIDGE = 3'h2;
    localparam logic [2:0] OUTM_BDC_REV = 3'h4;
    localparam logic [2:0] OUTM_BDC_FWD = 3'h5;
    localparam logic [2:0] OUTM_SCAN = 3'h6;
endpackage
